// file: bench/tb_top.sv
// Self-checking bench for the over-temperature trip and fan limit block
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {logic [7:0] addr; logic [7:0] exp;} otfl_row_t;
  logic mclk, srst, reg_wr, reg_rd, lock, main_power_good, monitor_tick, overtemp_trip_out_n, irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, temp_ambient, temp_remote1, temp_remote2;
  logic [7:0] fan1_duty_req, fan2_duty_req, fan3_duty_req, fan1_duty, fan2_duty, fan3_duty;
  logic [1:0] fan1_temp_resolution_sel, fan2_temp_resolution_sel, fan3_temp_resolution_sel;
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;
  otfl_row_t rows [16];

  otfl_trip_fan dut (.mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lock(lock),
    .main_power_good(main_power_good), .monitor_tick(monitor_tick),
    .temp_ambient(temp_ambient), .temp_remote1(temp_remote1), .temp_remote2(temp_remote2),
    .fan1_duty_req(fan1_duty_req), .fan2_duty_req(fan2_duty_req),
    .fan3_duty_req(fan3_duty_req), .fan1_duty(fan1_duty), .fan2_duty(fan2_duty),
    .fan3_duty(fan3_duty), .fan1_temp_resolution_sel(fan1_temp_resolution_sel),
    .fan2_temp_resolution_sel(fan2_temp_resolution_sel),
    .fan3_temp_resolution_sel(fan3_temp_resolution_sel),
    .overtemp_trip_out_n(overtemp_trip_out_n), .irq(irq));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic summarize;
    if (n_mismatch == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk8(reg_rdata, exp);
  endtask

  // Ticks two cycles apart, then one settling edge
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk);
      monitor_tick <= 1'b1;
      @(posedge mclk);
      monitor_tick <= 1'b0;
    end
    @(posedge mclk);
    #1;
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      summarize;
    end
  end

  initial begin
    rows = '{'{8'hbd, 8'h00}, '{8'hbf, 8'h00}, '{8'hc0, 8'h00}, '{8'hc1, 8'h01},
      '{8'hc4, 8'h7f}, '{8'hc5, 8'h7f}, '{8'hc9, 8'h7f}, '{8'hca, 8'h00},
      '{8'hcb, 8'h00}, '{8'hce, 8'h00}, '{8'hd1, 8'hff}, '{8'hd6, 8'hff},
      '{8'hdb, 8'hff}, '{8'he0, 8'h00}, '{8'h00, 8'h00}, '{8'hc2, 8'h00}};
    srst = 1'b1;
    {reg_wr, reg_rd, lock, monitor_tick} = 4'h0;
    main_power_good = 1'b1;
    {reg_addr, reg_wdata, temp_ambient, temp_remote1} = 32'h0;
    temp_remote2 = 8'h80;
    {fan1_duty_req, fan2_duty_req, fan3_duty_req} = 24'hffffff;
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    #1;
    chk1(overtemp_trip_out_n, 1'b1);
    chk1(irq, 1'b0);
    chk8(fan1_duty, 8'h00);
    foreach (rows[i]) rd(rows[i].addr, rows[i].exp);
    @(posedge mclk);
    lock <= 1'b1;
    wr(8'hc4, 8'h55);
    wr(8'hcb, 8'h07);
    wr(8'hd1, 8'h40);
    rd(8'hc4, 8'h7f);
    rd(8'hcb, 8'h00);
    rd(8'hd1, 8'hff);
    @(posedge mclk);
    lock <= 1'b0;
    wr(8'hbd, 8'ha5);
    rd(8'hbd, 8'h00);
    wr(8'hbf, 8'ha5);
    rd(8'hbf, 8'ha5);
    wr(8'hcb, 8'hff);
    rd(8'hcb, 8'h07);
    wr(8'hc1, 8'hff);
    rd(8'hc1, 8'h03);
    wr(8'he0, 8'hf9);
    rd(8'he0, 8'h39);
    chk8({2'h0, fan3_temp_resolution_sel, fan2_temp_resolution_sel, fan1_temp_resolution_sel},
      8'h39);
    wr(8'hd1, 8'h40);
    fan1_duty_req <= 8'h80;
    fan2_duty_req <= 8'h12;
    repeat (2) @(posedge mclk);
    #1;
    chk8(fan1_duty, 8'h40);
    chk8(fan2_duty, 8'h12);
    chk8(fan3_duty, 8'hff);
    wr(8'hc9, 8'h10);
    wr(8'hce, 8'h07);
    temp_ambient <= 8'h11;
    temp_remote1 <= 8'h7f;
    // Equal and most negative readings must not trip
    tick(1);
    rd(8'hca, 8'h00);
    chk1(overtemp_trip_out_n, 1'b1);
    tick(1);
    rd(8'hca, 8'h01);
    chk1(overtemp_trip_out_n, 1'b0);
    chk1(irq, 1'b1);
    wr(8'hca, 8'h01);
    rd(8'hca, 8'h01);
    wr(8'hc1, 8'h00);
    rd(8'hc1, 8'h01);
    chk1(overtemp_trip_out_n, 1'b1);
    wr(8'hc1, 8'h02);
    wr(8'hcb, 8'h06);
    rd(8'hcb, 8'h06);
    chk1(overtemp_trip_out_n, 1'b1);
    wr(8'hcb, 8'h07);
    wr(8'hce, 8'h06);
    rd(8'hce, 8'h06);
    chk1(irq, 1'b0);
    wr(8'hce, 8'h07);
    temp_ambient <= 8'h10;
    tick(1);
    wr(8'hca, 8'h01);
    rd(8'hca, 8'h00);
    chk1(overtemp_trip_out_n, 1'b1);
    wr(8'hc5, 8'hf0);
    temp_remote2 <= 8'hf1;
    tick(2);
    rd(8'hca, 8'h04);
    chk1(overtemp_trip_out_n, 1'b0);
    temp_remote2 <= 8'hf0;
    main_power_good <= 1'b0;
    tick(2);
    @(posedge mclk);
    main_power_good <= 1'b1;
    rd(8'hca, 8'h00);
    summarize;
  end
endmodule

// file: rtl/otfl_pkg.sv
// Register map, field positions and reset values of the over-temperature trip block
package otfl_pkg;
  localparam logic [7:0] OFS_RSV_RO_BD = 8'hbd;
  localparam logic [7:0] OFS_RSV_BF = 8'hbf;
  localparam logic [7:0] OFS_RSV_C0 = 8'hc0;
  localparam logic [7:0] OFS_TRIP_CTRL = 8'hc1;
  localparam logic [7:0] OFS_LIMIT_REMOTE1 = 8'hc4;
  localparam logic [7:0] OFS_LIMIT_REMOTE2 = 8'hc5;
  localparam logic [7:0] OFS_LIMIT_AMBIENT = 8'hc9;
  localparam logic [7:0] OFS_TRIP_STATUS = 8'hca;
  localparam logic [7:0] OFS_TRIP_OE = 8'hcb;
  localparam logic [7:0] OFS_ZONE_IRQ_EN = 8'hce;
  localparam logic [7:0] OFS_FAN1_MAX = 8'hd1;
  localparam logic [7:0] OFS_FAN2_MAX = 8'hd6;
  localparam logic [7:0] OFS_FAN3_MAX = 8'hdb;
  localparam logic [7:0] OFS_FAN_RES = 8'he0;

  // Zone bit positions in status, enable and interrupt enable registers
  localparam int ZONE_AMBIENT = 0;
  localparam int ZONE_REMOTE1 = 1;
  localparam int ZONE_REMOTE2 = 2;
  localparam int NUM_ZONES = 3;
  localparam int NUM_FANS = 3;

  localparam int TRIP_CTRL_BIT = 1;
  localparam logic [7:0] RST_TRIP_CTRL = 8'h01;
  localparam logic [7:0] RST_LIMIT = 8'h7f;
  localparam logic [7:0] RST_MAX_DUTY = 8'hff;
  localparam logic [2:0] RST_ZONE_BITS = 3'h0;
  localparam logic [7:0] RST_RSV = 8'h00;
  localparam logic [5:0] RST_FAN_RES = 6'h00;
  localparam logic [7:0] RSV_RO_VALUE = 8'h00;

  // Resolution select codes for automatic fan control
  localparam logic [1:0] RES_1_DEG = 2'h0;
  localparam logic [1:0] RES_HALF_DEG = 2'h1;
  localparam logic [1:0] RES_QUARTER_DEG = 2'h2;
  localparam logic [1:0] RES_RESERVED = 2'h3;
endpackage

// file: rtl/otfl_trip_fan.sv
// Over-temperature trip logic, fan duty ceilings and resolution selects
// Operation
// RQ1 - Control bit 1 gates the trip pin; clear disables trip assertion.
// RQ2 - One 8-bit trip limit per zone, each resetting to 7f.
// RQ3 - Lock set makes limits, output enables and fan ceilings read-only.
// RQ4 - Trip compare uses only the trip limit, not the interrupt high limit.
// RQ5 - Status sets only after two consecutive monitoring cycles over limit.
// RQ6 - Per-zone output enable bits 2..0 gate the pin; reset disabled.
// RQ7 - Status bit 2 remote two, bit 1 remote one, bit 0 ambient.
// RQ8 - Status sticky; write one clears only when condition no longer active.
// RQ9 - Status returns to zero on main power good rising edge.
// RQ10 - Three fan duty ceilings reset to ff and cap automatic duty.
// RQ11 - Two-bit resolution field per fan selects 1, 0.5, 0.25 degree steps.
// RQ12 - Finer fan resolution never restricts the reported temperature range.
// RQ13 - Reserved registers are zero-reset storage, one read-only location.
// RQ14 - Trip pin active low: OR of enabled status bits, gated by control.
// RQ15 - Reserved bits in documented registers read zero, ignore writes.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module otfl_trip_fan (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic lock,
  input wire logic main_power_good,
  input wire logic monitor_tick,
  input wire logic [7:0] temp_ambient,
  input wire logic [7:0] temp_remote1,
  input wire logic [7:0] temp_remote2,
  input wire logic [7:0] fan1_duty_req,
  input wire logic [7:0] fan2_duty_req,
  input wire logic [7:0] fan3_duty_req,
  output logic [7:0] fan1_duty,
  output logic [7:0] fan2_duty,
  output logic [7:0] fan3_duty,
  output logic [1:0] fan1_temp_resolution_sel,
  output logic [1:0] fan2_temp_resolution_sel,
  output logic [1:0] fan3_temp_resolution_sel,
  output logic overtemp_trip_out_n,
  output logic irq
);

  typedef struct packed {
    logic trip_en;
    logic [2:0][7:0] limit;
    logic [2:0] status;
    logic [2:0] oe;
    logic [2:0] irq_en;
    logic [7:0] rsv_bf;
    logic [7:0] rsv_c0;
    logic [2:0][7:0] max_duty;
    logic [5:0] fan_res;
    logic [2:0] prev_exceed;
    logic [2:0] active;
    logic pg_d;
    logic [7:0] rdata;
    logic trip_n;
    logic [2:0][7:0] duty;
  } otfl_state_t;

  localparam otfl_state_t RST_STATE = '{
    trip_en: otfl_pkg::RST_TRIP_CTRL[otfl_pkg::TRIP_CTRL_BIT],
    limit: {3{otfl_pkg::RST_LIMIT}},
    status: otfl_pkg::RST_ZONE_BITS,
    oe: otfl_pkg::RST_ZONE_BITS,
    irq_en: otfl_pkg::RST_ZONE_BITS,
    rsv_bf: otfl_pkg::RST_RSV,
    rsv_c0: otfl_pkg::RST_RSV,
    max_duty: {3{otfl_pkg::RST_MAX_DUTY}},
    fan_res: otfl_pkg::RST_FAN_RES,
    prev_exceed: otfl_pkg::RST_ZONE_BITS,
    active: otfl_pkg::RST_ZONE_BITS,
    pg_d: 1'b0,
    rdata: 8'h00,
    trip_n: 1'b1,
    duty: {3{8'h00}}
  };

  otfl_state_t st;
  otfl_state_t next_st;
  logic [2:0][7:0] temp;
  logic [2:0][7:0] duty_req;
  logic [2:0] exceed;
  logic [2:0] status_clr;
  logic wr_ok;

  always_comb begin
    temp[otfl_pkg::ZONE_AMBIENT] = temp_ambient;
    temp[otfl_pkg::ZONE_REMOTE1] = temp_remote1;
    temp[otfl_pkg::ZONE_REMOTE2] = temp_remote2;
    duty_req[0] = fan1_duty_req;
    duty_req[1] = fan2_duty_req;
    duty_req[2] = fan3_duty_req;
  end

  // Per-zone compare against the dedicated trip limit only
  for (genvar z = 0; z < otfl_pkg::NUM_ZONES; z++) begin : g_zone
    assign exceed[z] = $signed(temp[z]) > $signed(st.limit[z]); // RQ4
  end

  // Limits, output enables and ceilings freeze while locked
  assign wr_ok = reg_wr && !lock; // RQ3

  always_comb begin
    next_st = st;
    // Qualification: only the tick samples, so a one-cycle glitch cannot trip
    if (monitor_tick) begin
      next_st.prev_exceed = exceed;
      next_st.active = exceed & st.prev_exceed; // RQ5
    end
    // Clear only zones whose qualified condition has gone away
    status_clr = '0;
    if (reg_wr && reg_addr == otfl_pkg::OFS_TRIP_STATUS) begin
      status_clr = reg_wdata[2:0] & ~next_st.active; // RQ8
    end
    next_st.status = (st.status & ~status_clr) | next_st.active; // RQ7
    next_st.pg_d = main_power_good;
    if (main_power_good && !st.pg_d) begin
      next_st.status = otfl_pkg::RST_ZONE_BITS; // RQ9
    end
    if (reg_wr) begin
      unique case (reg_addr)
        otfl_pkg::OFS_RSV_BF: next_st.rsv_bf = reg_wdata; // RQ13
        otfl_pkg::OFS_RSV_C0: next_st.rsv_c0 = reg_wdata; // RQ13
        otfl_pkg::OFS_TRIP_CTRL: next_st.trip_en = reg_wdata[otfl_pkg::TRIP_CTRL_BIT]; // RQ1
        otfl_pkg::OFS_ZONE_IRQ_EN: next_st.irq_en = reg_wdata[2:0]; // RQ15
        otfl_pkg::OFS_FAN_RES: next_st.fan_res = reg_wdata[5:0]; // RQ11
        default: ;
      endcase
    end
    if (wr_ok) begin
      unique case (reg_addr)
        otfl_pkg::OFS_LIMIT_AMBIENT: next_st.limit[otfl_pkg::ZONE_AMBIENT] = reg_wdata; // RQ2
        otfl_pkg::OFS_LIMIT_REMOTE1: next_st.limit[otfl_pkg::ZONE_REMOTE1] = reg_wdata; // RQ2
        otfl_pkg::OFS_LIMIT_REMOTE2: next_st.limit[otfl_pkg::ZONE_REMOTE2] = reg_wdata; // RQ2
        otfl_pkg::OFS_TRIP_OE: next_st.oe = reg_wdata[2:0]; // RQ6
        otfl_pkg::OFS_FAN1_MAX: next_st.max_duty[0] = reg_wdata; // RQ10
        otfl_pkg::OFS_FAN2_MAX: next_st.max_duty[1] = reg_wdata; // RQ10
        otfl_pkg::OFS_FAN3_MAX: next_st.max_duty[2] = reg_wdata; // RQ10
        default: ;
      endcase
    end
    // Pin follows the status it is built from in the same cycle
    // Control and enables as they stand after this edge, so pin and registers agree
    next_st.trip_n = !(next_st.trip_en && |(next_st.status & next_st.oe)); // RQ14 RQ1 RQ6
    // Cap is a pure clamp; the request path itself is never scaled
    for (int f = 0; f < otfl_pkg::NUM_FANS; f++) begin
      next_st.duty[f] = (duty_req[f] > st.max_duty[f]) ? st.max_duty[f] : duty_req[f]; // RQ10
    end
    next_st.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        otfl_pkg::OFS_RSV_RO_BD: next_st.rdata = otfl_pkg::RSV_RO_VALUE; // RQ13
        otfl_pkg::OFS_RSV_BF: next_st.rdata = st.rsv_bf;
        otfl_pkg::OFS_RSV_C0: next_st.rdata = st.rsv_c0;
        otfl_pkg::OFS_TRIP_CTRL: next_st.rdata = {6'h00, st.trip_en, 1'b1}; // RQ15
        otfl_pkg::OFS_LIMIT_AMBIENT: next_st.rdata = st.limit[otfl_pkg::ZONE_AMBIENT];
        otfl_pkg::OFS_LIMIT_REMOTE1: next_st.rdata = st.limit[otfl_pkg::ZONE_REMOTE1];
        otfl_pkg::OFS_LIMIT_REMOTE2: next_st.rdata = st.limit[otfl_pkg::ZONE_REMOTE2];
        otfl_pkg::OFS_TRIP_STATUS: next_st.rdata = {5'h00, st.status}; // RQ15
        otfl_pkg::OFS_TRIP_OE: next_st.rdata = {5'h00, st.oe};
        otfl_pkg::OFS_ZONE_IRQ_EN: next_st.rdata = {5'h00, st.irq_en};
        otfl_pkg::OFS_FAN1_MAX: next_st.rdata = st.max_duty[0];
        otfl_pkg::OFS_FAN2_MAX: next_st.rdata = st.max_duty[1];
        otfl_pkg::OFS_FAN3_MAX: next_st.rdata = st.max_duty[2];
        otfl_pkg::OFS_FAN_RES: next_st.rdata = {2'h0, st.fan_res};
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st <= RST_STATE;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign overtemp_trip_out_n = st.trip_n;
  assign irq = |(st.status & st.irq_en);
  assign fan1_duty = st.duty[0];
  assign fan2_duty = st.duty[1];
  assign fan3_duty = st.duty[2];
  // Select only steers the fan's temperature step; readings stay full range
  assign fan1_temp_resolution_sel = st.fan_res[1:0]; // RQ11 RQ12
  assign fan2_temp_resolution_sel = st.fan_res[3:2]; // RQ11 RQ12
  assign fan3_temp_resolution_sel = st.fan_res[5:4]; // RQ11 RQ12

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // Second consecutive tick over limit on one zone
  sequence s_two_ticks_over(int z);
    monitor_tick && exceed[z] && st.prev_exceed[z];
  endsequence

  sequence s_wr_open(logic [7:0] a);
    reg_wr && !lock && reg_addr == a;
  endsequence

  sequence s_wr_any(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence

  sequence s_rd_at(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence

  a_trip_pin_gate: assert property ( // RQ14
    overtemp_trip_out_n == !(st.trip_en && |(st.status & st.oe))
  ) else $error("trip pin does not match enabled status");

  a_trip_ctrl_off: assert property ( // RQ1
    !st.trip_en |-> overtemp_trip_out_n
  ) else $error("trip pin active while control bit clear");

  a_qual_two_cycles: assert property ( // RQ5
    (monitor_tick && !st.prev_exceed[0] && st.status[0] == 1'b0
      && !(main_power_good && !st.pg_d)) |=> !st.active[0]
  ) else $error("ambient qualified after one monitoring cycle");

  a_qual_set: assert property ( // RQ5
    (s_two_ticks_over(1) ##0 !(main_power_good && !st.pg_d)) |=> st.status[1]
  ) else $error("remote one status not set after two cycles over");

  a_status_sticky: assert property ( // RQ8
    (st.status[2] && st.active[2] && !monitor_tick
      && !(main_power_good && !st.pg_d)) |=> st.status[2]
  ) else $error("status cleared while condition active");

  a_w1c_clear: assert property ( // RQ8
    (reg_wr && reg_addr == otfl_pkg::OFS_TRIP_STATUS && reg_wdata[0]
      && !monitor_tick && !st.active[0]) |=> !st.status[0]
  ) else $error("inactive status bit not cleared by write one");

  a_pg_clear: assert property ( // RQ9
    (main_power_good && !st.pg_d) |=> st.status == 3'h0
  ) else $error("status not zeroed on power good rise");

  a_lock_hold: assert property ( // RQ3
    (lock && reg_wr) |=> $stable(st.limit) && $stable(st.oe) && $stable(st.max_duty)
  ) else $error("locked register changed on write");

  a_duty_cap: assert property ( // RQ10
    ##1 (fan1_duty <= $past(st.max_duty[0]) && fan2_duty <= $past(st.max_duty[1])
      && fan3_duty <= $past(st.max_duty[2]))
  ) else $error("fan duty above ceiling");

  a_rdata_status: assert property ( // RQ15
    (reg_rd && reg_addr == otfl_pkg::OFS_TRIP_STATUS) |=>
      reg_rdata == {5'h00, $past(st.status)}
  ) else $error("status read back wrong or late");

  a_rdata_idle: assert property ( // RQ15
    !reg_rd |=> reg_rdata == 8'h00
  ) else $error("read data present without a read");

  a_limit_amb_wr: assert property ( // RQ2
    s_wr_open(otfl_pkg::OFS_LIMIT_AMBIENT) |=> st.limit[0] == $past(reg_wdata)
  ) else $error("ambient limit write lost");

  a_limit_r1_wr: assert property ( // RQ2
    s_wr_open(otfl_pkg::OFS_LIMIT_REMOTE1) |=> st.limit[1] == $past(reg_wdata)
  ) else $error("remote one limit write lost");

  a_limit_r2_wr: assert property ( // RQ2
    s_wr_open(otfl_pkg::OFS_LIMIT_REMOTE2) |=> st.limit[2] == $past(reg_wdata)
  ) else $error("remote two limit write lost");

  a_oe_wr: assert property ( // RQ6
    s_wr_open(otfl_pkg::OFS_TRIP_OE) |=> st.oe == $past(reg_wdata[2:0])
  ) else $error("output enable write lost");

  a_fan1_max_wr: assert property ( // RQ10
    s_wr_open(otfl_pkg::OFS_FAN1_MAX) |=> st.max_duty[0] == $past(reg_wdata)
  ) else $error("fan one ceiling write lost");

  a_fan2_max_wr: assert property ( // RQ10
    s_wr_open(otfl_pkg::OFS_FAN2_MAX) |=> st.max_duty[1] == $past(reg_wdata)
  ) else $error("fan two ceiling write lost");

  a_fan3_max_wr: assert property ( // RQ10
    s_wr_open(otfl_pkg::OFS_FAN3_MAX) |=> st.max_duty[2] == $past(reg_wdata)
  ) else $error("fan three ceiling write lost");

  a_ctrl_wr: assert property ( // RQ1
    s_wr_any(otfl_pkg::OFS_TRIP_CTRL) |=> st.trip_en == $past(reg_wdata[1])
  ) else $error("trip control write lost");

  a_res_wr: assert property ( // RQ11
    s_wr_any(otfl_pkg::OFS_FAN_RES) |=> st.fan_res == $past(reg_wdata[5:0])
  ) else $error("resolution write lost");

  a_irq_en_wr: assert property ( // RQ15
    s_wr_any(otfl_pkg::OFS_ZONE_IRQ_EN) |=> st.irq_en == $past(reg_wdata[2:0])
  ) else $error("interrupt enable write lost");

  a_rsv_bf_wr: assert property ( // RQ13
    s_wr_any(otfl_pkg::OFS_RSV_BF) |=> st.rsv_bf == $past(reg_wdata)
  ) else $error("reserved bf write lost");

  a_rsv_c0_wr: assert property ( // RQ13
    s_wr_any(otfl_pkg::OFS_RSV_C0) |=> st.rsv_c0 == $past(reg_wdata)
  ) else $error("reserved c0 write lost");

  a_rdata_ctrl: assert property ( // RQ15
    s_rd_at(otfl_pkg::OFS_TRIP_CTRL) |=> reg_rdata == {6'h00, $past(st.trip_en), 1'b1}
  ) else $error("control read back wrong");

  a_rdata_oe: assert property ( // RQ15
    s_rd_at(otfl_pkg::OFS_TRIP_OE) |=> reg_rdata == {5'h00, $past(st.oe)}
  ) else $error("output enable read back wrong");

  a_rdata_bd: assert property ( // RQ13
    s_rd_at(otfl_pkg::OFS_RSV_RO_BD) |=> reg_rdata == otfl_pkg::RSV_RO_VALUE
  ) else $error("read-only reserved location read back wrong");

  a_rdata_irq_en: assert property ( // RQ15
    s_rd_at(otfl_pkg::OFS_ZONE_IRQ_EN) |=> reg_rdata == {5'h00, $past(st.irq_en)}
  ) else $error("interrupt enable read back wrong");

  a_rdata_res: assert property ( // RQ15
    s_rd_at(otfl_pkg::OFS_FAN_RES) |=> reg_rdata == {2'h0, $past(st.fan_res)}
  ) else $error("resolution read back wrong");

  a_rdata_limit_amb: assert property ( // RQ2
    s_rd_at(otfl_pkg::OFS_LIMIT_AMBIENT) |=> reg_rdata == $past(st.limit[0])
  ) else $error("ambient limit read back wrong");

  a_rdata_limit_r2: assert property ( // RQ2
    s_rd_at(otfl_pkg::OFS_LIMIT_REMOTE2) |=> reg_rdata == $past(st.limit[2])
  ) else $error("remote two limit read back wrong");

  a_rdata_fan1_max: assert property ( // RQ10
    s_rd_at(otfl_pkg::OFS_FAN1_MAX) |=> reg_rdata == $past(st.max_duty[0])
  ) else $error("fan one ceiling read back wrong");

  a_res_outputs: assert property ( // RQ11
    {fan3_temp_resolution_sel, fan2_temp_resolution_sel, fan1_temp_resolution_sel} == st.fan_res
  ) else $error("resolution selects differ from register");

  a_irq_level: assert property ( // RQ7
    irq == |(st.status & st.irq_en)
  ) else $error("interrupt level differs from masked status");

  a_duty_pass1: assert property ( // RQ10
    (fan1_duty_req <= st.max_duty[0]) |=> fan1_duty == $past(fan1_duty_req)
  ) else $error("fan one request below ceiling not passed");

  a_duty_pass2: assert property ( // RQ10
    (fan2_duty_req <= st.max_duty[1]) |=> fan2_duty == $past(fan2_duty_req)
  ) else $error("fan two request below ceiling not passed");

  a_status_rise: assert property ( // RQ5
    $rose(st.status[0]) |-> st.active[0]
  ) else $error("ambient status set without qualification");

  a_trip_enabled: assert property ( // RQ6
    (st.trip_en && |(st.status & st.oe)) |-> !overtemp_trip_out_n
  ) else $error("trip pin idle with enabled status set");

endmodule
